// ### hdl/scl_serial_config_loader.sv
`timescale 1ns/100ps
`include "scl_defines.svh"
module scl_serial_config_loader #(
    parameter int INIT_MAX_CYC = (`SCL_INIT_MAX_US * 1000) / `SCL_CLK_NS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration clock pin, two-way
    input wire logic configClockIn,
    output logic configClockOut,
    output logic configClockOe,
    // Serial data pins
    input wire logic serialConfigIn,
    input wire logic [3:0] quadSerialData,
    output logic serialCmdOut,
    output logic serialCmdOe,
    output logic serialConfigUserIo,
    // Handshake pins, open drain
    input wire logic reconfigRequestN,
    input wire logic configStatusNIn,
    output logic configStatusNOut,
    output logic configStatusNOe,
    input wire logic configDoneLineIn,
    output logic configDoneLineOut,
    output logic configDoneLineOe,
    output logic initDoneOut,
    output logic initDoneOe,
    // Initialization user clock
    input wire logic userClockIn
);
    import scl_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int S_REQ = 9;
    localparam int S_STAT = 8;
    localparam int S_DONE = 7;
    localparam int S_CLK = 6;
    localparam int S_DAT = 5;
    localparam int S_USR = 0;

    logic [9:0] sync1_ff;
    logic [9:0] sync2_ff;
    logic [9:0] sync3_ff;

    // Every pin input crosses two flops; the third only feeds edge detection
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_ff <= 10'h380;
            sync2_ff <= 10'h380;
            sync3_ff <= 10'h380;
        end else begin
            sync1_ff <= {reconfigRequestN, configStatusNIn, configDoneLineIn, configClockIn,
                         serialConfigIn, quadSerialData, userClockIn};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    wire reqHigh = sync2_ff[S_REQ];
    wire statusHigh = sync2_ff[S_STAT];
    wire doneHigh = sync2_ff[S_DONE];
    wire [3:0] quadIn = sync2_ff[4:1];
    wire psRise = sync2_ff[S_CLK] & ~sync3_ff[S_CLK];
    wire psFall = ~sync2_ff[S_CLK] & sync3_ff[S_CLK];
    wire usrRise = sync2_ff[S_USR] & ~sync3_ff[S_USR];

    // ----------------------------------------
    // APB register file
    // ----------------------------------------
    logic [7:0] ctrl_ff;
    logic [31:0] len_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    scl_state_t state_ff;
    scl_state_t nxt_state;
    logic [31:0] bitCnt_ff;
    logic [31:0] shiftData_ff;

    wire isActive = ctrl_ff[`SCL_CTRL_ACTIVE];
    wire isQuad = ctrl_ff[`SCL_CTRL_QUAD];
    wire [1:0] spdSel = ctrl_ff[`SCL_CTRL_SPD +: 2];
    wire inChain = ctrl_ff[`SCL_CTRL_CHAIN];
    wire useUsr = ctrl_ff[`SCL_CTRL_USRCLK];
    wire initEn = ctrl_ff[`SCL_CTRL_INITEN];
    wire dualIo = ctrl_ff[`SCL_CTRL_DUALIO];

    // Address decode and read selection
    wire setupPh = psel & ~penable;
    wire wrEn = psel & penable & pready_ff & pwrite;
    wire hitCtrl = paddr == `SCL_OFS_CTRL;
    wire hitLen = paddr == `SCL_OFS_LEN;
    wire hitStat = paddr == `SCL_OFS_STAT;
    wire hitCount = paddr == `SCL_OFS_COUNT;
    wire hitData = paddr == `SCL_OFS_DATA;
    wire mapped = hitCtrl | hitLen | hitStat | hitCount | hitData;
    wire [31:0] statWord = {27'h0, state_ff == SCL_USER, ~configDoneLineOe, state_ff};
    wire [31:0] rdMux = hitCtrl ? {24'h0, ctrl_ff} :
                        hitLen ? len_ff :
                        hitStat ? statWord :
                        hitCount ? bitCnt_ff :
                        hitData ? shiftData_ff : 32'h0;

    // Zero wait states: the access phase always completes on its first edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= setupPh;
            pslverr_ff <= setupPh & ~mapped;
            prdata_ff <= setupPh ? rdMux : prdata_ff;
        end
    end

    // Software options; status and counters are read only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_ff <= `SCL_CTRL_RST;
            len_ff <= `SCL_LEN_RST;
        end else begin
            ctrl_ff <= (wrEn & hitCtrl) ? pwdata[7:0] : ctrl_ff;
            len_ff <= (wrEn & hitLen) ? pwdata : len_ff;
        end
    end

    // ----------------------------------------
    // Generated configuration clock
    // ----------------------------------------
    function automatic logic [3:0] scl_half(input logic [1:0] spd, input logic chain);
        logic [1:0] s;
        s = (chain && spd == 2'd3) ? 2'd2 : spd;
        case (s)
            2'd0: scl_half = `SCL_HALF_S0;
            2'd1: scl_half = `SCL_HALF_S1;
            2'd2: scl_half = `SCL_HALF_S2;
            default: scl_half = `SCL_HALF_S3;
        endcase
    endfunction : scl_half

    logic [3:0] halfCnt_ff;
    logic config_clock_ff;
    logic clkOe_ff;

    wire [3:0] halfLen = scl_half(spdSel, inChain);
    wire dclkRun = isActive & (state_ff == SCL_LOAD || state_ff == SCL_FLUSH);
    wire halfEnd = halfCnt_ff >= halfLen - 4'd1;
    wire fallTick = dclkRun & halfEnd & config_clock_ff;
    wire [3:0] nxt_halfCnt = (!dclkRun || halfEnd) ? 4'h0 : halfCnt_ff + 4'd1;
    wire nxt_config_clock = dclkRun & (halfEnd ? ~config_clock_ff : config_clock_ff);

    // The clock only runs while this end is in LOAD or FLUSH; it idles low
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            halfCnt_ff <= 4'h0;
            config_clock_ff <= 1'b0;
            clkOe_ff <= 1'b0;
        end else begin
            halfCnt_ff <= nxt_halfCnt;
            config_clock_ff <= nxt_config_clock;
            clkOe_ff <= isActive & (nxt_state == SCL_LOAD || nxt_state == SCL_FLUSH);
        end
    end

    // ----------------------------------------
    // Command out and data capture
    // ----------------------------------------
    logic [5:0] cmdCnt_ff;
    logic [31:0] cmdShift_ff;
    logic cmdOut_ff;
    logic cmdOe_ff;
    logic [1:0] capPipe_ff;

    wire inLoad = state_ff == SCL_LOAD;
    wire cmdPhase = isActive & (cmdCnt_ff < `SCL_CMD_BITS);
    wire cmdTick = inLoad & fallTick & cmdPhase;
    wire capFall = isActive & inLoad & fallTick & ~cmdPhase;
    // Active capture trails the fall by the synchroniser depth, so the fastest setting still works
    wire capEv = inLoad & (isActive ? capPipe_ff[1] : psRise);
    wire quadCap = isActive & isQuad;
    wire [31:0] capBits = quadCap ? 32'd4 : 32'd1;
    wire oneBit = isActive ? quadIn[1] : sync2_ff[S_DAT];
    wire [31:0] nxt_shift = quadCap ? {shiftData_ff[27:0], quadIn} : {shiftData_ff[30:0], oneBit};
    wire stateChange = nxt_state != state_ff;

    // Input data is sampled through the synchroniser, so it is seen two system cycles late
    always_ff @(posedge clk_sys) begin
        if (reset || state_ff == SCL_RESET) begin
            cmdCnt_ff <= 6'h0;
            cmdShift_ff <= `SCL_CMD_WORD;
            cmdOut_ff <= 1'b0;
            bitCnt_ff <= 32'h0;
            shiftData_ff <= 32'h0;
            capPipe_ff <= 2'h0;
        end else begin
            capPipe_ff <= {capPipe_ff[0], capFall};
            cmdCnt_ff <= cmdTick ? cmdCnt_ff + 6'd1 : cmdCnt_ff;
            cmdShift_ff <= cmdTick ? {cmdShift_ff[30:0], 1'b0} : cmdShift_ff;
            cmdOut_ff <= cmdTick ? cmdShift_ff[31] : cmdOut_ff;
            bitCnt_ff <= capEv ? bitCnt_ff + capBits : bitCnt_ff;
            shiftData_ff <= capEv ? nxt_shift : shiftData_ff;
        end
    end

    // ----------------------------------------
    // Sequence control
    // ----------------------------------------
    logic [31:0] cnt_ff;
    logic [13:0] ucnt_ff;

    wire fallEv = isActive ? fallTick : psFall;
    wire [31:0] initLimit = useUsr ? `SCL_CD2CU_CYC : `SCL_INIT_MIN_CYC;
    wire initOver = useUsr ? (ucnt_ff >= `SCL_USER_EDGES) : (cnt_ff >= initLimit);
    wire cntInc = (state_ff == SCL_RESET && cnt_ff < `SCL_POR_CYC) ||
                  (state_ff == SCL_FLUSH && fallEv) ||
                  (state_ff == SCL_INIT && cnt_ff < initLimit);
    wire usrCount = state_ff == SCL_INIT && useUsr && cnt_ff >= initLimit && usrRise;
    wire extFault = (state_ff == SCL_INIT || state_ff == SCL_USER) && !statusHigh;

    // Next state; a low request, or a foreign status low in INIT or USER, forces a restart
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SCL_RESET: if (cnt_ff >= `SCL_POR_CYC && reqHigh) nxt_state = SCL_LOAD;
            SCL_LOAD: if (bitCnt_ff >= len_ff) nxt_state = SCL_FLUSH;
            SCL_FLUSH: if (cnt_ff >= `SCL_FLUSH_EDGES && doneHigh) nxt_state = SCL_INIT;
            SCL_INIT: if (initOver) nxt_state = SCL_USER;
            SCL_USER: nxt_state = SCL_USER;
            default: nxt_state = SCL_RESET;
        endcase
        if (!reqHigh || extFault) begin
            nxt_state = SCL_RESET;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= SCL_RESET;
            cnt_ff <= 32'h0;
            ucnt_ff <= 14'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= stateChange ? 32'h0 : (cntInc ? cnt_ff + 32'd1 : cnt_ff);
            ucnt_ff <= stateChange ? 14'h0 : (usrCount ? ucnt_ff + 14'd1 : ucnt_ff);
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    logic lowLevel_ff;
    logic statusOe_ff;
    logic doneOe_ff;
    logic initOe_ff;
    logic userIo_ff;

    // Open-drain lines only ever pull low; release lets the pull-up win
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lowLevel_ff <= 1'b0;
            statusOe_ff <= 1'b1;
            doneOe_ff <= 1'b1;
            initOe_ff <= 1'b0;
            userIo_ff <= 1'b0;
            cmdOe_ff <= 1'b0;
        end else begin
            lowLevel_ff <= 1'b0;
            statusOe_ff <= nxt_state == SCL_RESET;
            doneOe_ff <= nxt_state == SCL_RESET || nxt_state == SCL_LOAD;
            initOe_ff <= initEn & (nxt_state == SCL_FLUSH || nxt_state == SCL_INIT);
            userIo_ff <= dualIo & (nxt_state == SCL_USER);
            cmdOe_ff <= isActive & (nxt_state == SCL_LOAD || nxt_state == SCL_FLUSH);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign configClockOut = config_clock_ff;
    assign configClockOe = clkOe_ff;
    assign serialCmdOut = cmdOut_ff;
    assign serialCmdOe = cmdOe_ff;
    assign serialConfigUserIo = userIo_ff;
    assign configStatusNOut = lowLevel_ff;
    assign configStatusNOe = statusOe_ff;
    assign configDoneLineOut = lowLevel_ff;
    assign configDoneLineOe = doneOe_ff;
    assign initDoneOut = lowLevel_ff;
    assign initDoneOe = initOe_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_status_por: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == SCL_RESET && cnt_ff < `SCL_POR_CYC) |=> configStatusNOe)
        else $error("status line released before power-on delay");
    a_done_low: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == SCL_LOAD && bitCnt_ff < len_ff) |=> configDoneLineOe)
        else $error("done line released while loading");
    a_done_full: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(configDoneLineOe) |-> bitCnt_ff >= len_ff)
        else $error("done released before whole bitstream");
    a_reconfig_abort: assert property (@(posedge clk_sys) disable iff (reset)
        !reqHigh |=> state_ff == SCL_RESET && configStatusNOe)
        else $error("request low did not restart configuration");
    a_user_lines: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == SCL_USER) |-> !configStatusNOe && !configDoneLineOe)
        else $error("status or done held low in user mode");
    a_osc_window: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == SCL_INIT && nxt_state == SCL_USER && !useUsr) |->
        cnt_ff >= `SCL_INIT_MIN_CYC && cnt_ff < INIT_MAX_CYC)
        else $error("oscillator init outside its window");
    a_usr_init: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == SCL_INIT && nxt_state == SCL_USER && useUsr) |->
        cnt_ff >= `SCL_CD2CU_CYC && ucnt_ff == `SCL_USER_EDGES)
        else $error("user clock init ended at wrong count");
    a_chain_speed: assert property (@(posedge clk_sys) disable iff (reset)
        (dclkRun && inChain) |-> halfLen != `SCL_HALF_S3)
        else $error("fastest clock used in a chain");
    a_quad_capture: assert property (@(posedge clk_sys) disable iff (reset)
        (capEv && quadCap) |=> bitCnt_ff == $past(bitCnt_ff) + 32'd4)
        else $error("quad capture did not take four bits");
    a_ps_capture: assert property (@(posedge clk_sys) disable iff (reset)
        (inLoad && !isActive && psRise) |=> bitCnt_ff == $past(bitCnt_ff) + 32'd1)
        else $error("passive rising edge did not take one bit");
    a_initdone_low: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == SCL_INIT && initEn && !initOver && reqHigh && !extFault) |=> initDoneOe)
        else $error("init-done released before init ended");
    a_fall_launch: assert property (@(posedge clk_sys) disable iff (reset)
        cmdTick |=> !configClockOut && serialCmdOut == $past(cmdShift_ff[31]))
        else $error("command bit not launched at falling edge");

endmodule : scl_serial_config_loader

// ### hdl/scl_defines.svh
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define SCL_OFS_CTRL 8'h00
`define SCL_OFS_LEN 8'h04
`define SCL_OFS_STAT 8'h08
`define SCL_OFS_COUNT 8'h0c
`define SCL_OFS_DATA 8'h10
`define SCL_CTRL_ACTIVE 0
`define SCL_CTRL_QUAD 1
`define SCL_CTRL_SPD 2
`define SCL_CTRL_CHAIN 4
`define SCL_CTRL_USRCLK 5
`define SCL_CTRL_INITEN 6
`define SCL_CTRL_DUALIO 7
`define SCL_CTRL_RST 8'h00
`define SCL_LEN_RST 32'h0000_0100
// ----------------------------------------
// Timing
// ----------------------------------------
`define SCL_CLK_NS 100
`define SCL_POR_US 268
`define SCL_POR_CYC ((`SCL_POR_US * 1000 + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`define SCL_INIT_MIN_US 175
`define SCL_INIT_MIN_CYC ((`SCL_INIT_MIN_US * 1000 + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`define SCL_INIT_MAX_US 437
`define SCL_USER_EDGES 8576
`define SCL_FLUSH_EDGES 2
// Half periods of the generated clock, in system cycles (0.625, 1.25, 2.5, 5.0 MHz settings)
`define SCL_HALF_S0 4'h8
`define SCL_HALF_S1 4'h4
`define SCL_HALF_S2 4'h2
`define SCL_HALF_S3 4'h1
`define SCL_CD2CU_CYC (4 * 2 * 8)
`define SCL_CMD_WORD 32'h0300_0000
`define SCL_CMD_BITS 6'h20
`endif

// ### hdl/scl_pkg.sv
package scl_pkg;
    // Loader sequence states
    typedef enum logic [2:0] {
        SCL_RESET = 3'b000,
        SCL_LOAD = 3'b001,
        SCL_FLUSH = 3'b010,
        SCL_INIT = 3'b011,
        SCL_USER = 3'b100
    } scl_state_t;
endpackage : scl_pkg

// ### verification/scl_far_side.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far side of the loader: a passive host and a serial flash
// ----------------------------------------
module scl_far_side (
    // Clock and shared stream image
    input wire logic clk_sys,
    input wire logic [127:0] image,
    input wire logic hostGo,
    input wire logic [7:0] hostBits,
    // Board-level view of the device pins
    input wire logic configClockOut,
    input wire logic configClockOe,
    input wire logic serialCmdOut,
    input wire logic statusWire,
    input wire logic doneWire,
    // Driven by the far side
    output logic hostClock,
    output logic hostData,
    output logic [3:0] flashData,
    output logic [31:0] cmdSeen
);
    int falls = 0;
    logic prevClk = 1'b0;
    logic hostDrive = 1'b0;

    initial begin
        hostClock = 1'b0;
        hostData = 1'b0;
        flashData = 4'h0;
        cmdSeen = 32'h0;
    end

    // Released data line toggles so a stale bit can never pass for a good one
    always @(posedge clk_sys) begin
        if (!hostDrive)
            hostData <= ~hostData;
    end

    // Host: 800 ns bit clock, data set while the clock is low
    always begin
        @(posedge clk_sys iff (hostGo && statusWire));
        hostDrive <= 1'b1;
        repeat (24) @(posedge clk_sys);
        for (int i = 0; i < hostBits; i++) begin
            hostData <= image[127 - i];
            hostClock <= 1'b0;
            repeat (4) @(posedge clk_sys);
            hostClock <= 1'b1;
            repeat (4) @(posedge clk_sys);
        end
        hostClock <= 1'b0;
        hostDrive <= 1'b0;
        for (int n = 0; n < 300 && !doneWire; n++) @(posedge clk_sys);
        // Extra rising edges on a short stream would fake the missing bits
        if (doneWire) begin
            repeat (2) begin
                repeat (4) @(posedge clk_sys);
                hostClock <= 1'b1;
                repeat (4) @(posedge clk_sys);
                hostClock <= 1'b0;
            end
        end
        @(posedge clk_sys iff !hostGo); // clock parked low
    end

    // Flash: command taken on rising edges, one nibble after each of falling edges 32 to 63
    always @(posedge clk_sys) begin
        prevClk <= configClockOut;
        if (!configClockOe) begin
            falls <= 0;
            flashData <= ~flashData;
        end else if (prevClk && !configClockOut) begin
            falls <= falls + 1;
            if (falls >= 31 && falls < 63)
                flashData <= image[127 - 4 * (falls - 31) -: 4];
        end else if (!prevClk && configClockOut && falls >= 1 && falls <= 32) begin
            cmdSeen <= {cmdSeen[30:0], serialCmdOut};
        end
    end
endmodule : scl_far_side

// ### verification/testbench.sv
`timescale 1ns/100ps
`include "scl_defines.svh"
module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, cmdSeen;
    logic pready, pslverr, configClockOut, configClockOe, serialCmdOut, serialCmdOe, serialConfigUserIo;
    logic configStatusNOut, configStatusNOe, configDoneLineOut, configDoneLineOe, initDoneOut, initDoneOe;
    logic reconfigRequestN = 1'b1, userClockIn = 1'b0, hostGo = 1'b0, hostClock, hostData;
    logic [1:0] uclkDiv = 2'h0;
    logic [3:0] flashData;
    logic [7:0] hostBits = 8'h00;
    logic [127:0] image = 128'h0;
    int errCount = 0, checked = 0;
    // Board wiring: shared clock pin, pulled-up open-drain lines
    wire cfgClk = configClockOe ? configClockOut : hostClock;
    wire statusWire = !configStatusNOe;
    wire doneWire = !configDoneLineOe;

    scl_serial_config_loader dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .configClockIn(cfgClk), .configClockOut, .configClockOe, .serialConfigIn(hostData),
        .quadSerialData(flashData), .serialCmdOut, .serialCmdOe, .serialConfigUserIo, .reconfigRequestN,
        .configStatusNIn(statusWire), .configStatusNOut, .configStatusNOe, .configDoneLineIn(doneWire),
        .configDoneLineOut, .configDoneLineOe, .initDoneOut, .initDoneOe, .userClockIn);
    scl_far_side far (.clk_sys, .image, .hostGo, .hostBits, .configClockOut, .configClockOe, .serialCmdOut,
        .statusWire, .doneWire, .hostClock, .hostData, .flashData, .cmdSeen);

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // Free-running user clock, 400 ns period
    always @(posedge clk_sys) begin
        uclkDiv <= uclkDiv + 2'h1;
        userClockIn <= uclkDiv[1];
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    // One APB transfer; the idle edge at the end keeps back-to-back calls legal
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check(32'(n < 20), 32'h1, "apb answer");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    // Restart, load a stream, then follow initialization into user mode when the whole stream was sent
    task automatic run(input logic [7:0] ctrl, input int len, input int sent);
        logic bits[$];
        logic [31:0] q;
        logic [31:0] expData = 32'h0;
        logic e;
        logic pu;
        int n, ue = 0, half = 0;
        image <= {$urandom, $urandom, $urandom, $urandom};
        hostGo <= 1'b0;
        hostBits <= 8'(sent);
        reconfigRequestN <= 1'b0;
        apb(1'b1, `SCL_OFS_CTRL, {24'h0, ctrl}, q, e);
        apb(1'b1, `SCL_OFS_LEN, 32'(len), q, e);
        repeat (20) @(posedge clk_sys); // low over 2 us
        check(32'(configStatusNOe & configDoneLineOe), 32'h1, "restart lines");
        reconfigRequestN <= 1'b1;
        hostGo <= ~ctrl[0];
        for (n = 0; n < 3000 && configStatusNOe; n++) @(posedge clk_sys);
        check(32'(n >= `SCL_POR_CYC - 60 && n <= `SCL_POR_CYC + 10), 32'h1, "status low span");
        if (ctrl[0]) begin
            for (n = 0; n < 300 && !configClockOut; n++) @(posedge clk_sys);
            for (half = 0; half < 20 && configClockOut; half++) @(posedge clk_sys);
            check(32'(half), 32'(ctrl[3:2] == 2'h0 ? `SCL_HALF_S0 : ctrl[3:2] == 2'h1 ? `SCL_HALF_S1 :
                (ctrl[3:2] == 2'h2 || ctrl[4]) ? `SCL_HALF_S2 : `SCL_HALF_S3), "clock half period");
            check(32'({serialCmdOe, configClockOe}), 32'h3, "link drivers on");
        end
        for (n = 0; n < 3000 && configDoneLineOe; n++) @(posedge clk_sys);
        if (sent == len) begin
            n = 0;
            pu = userClockIn;
            while (serialConfigUserIo !== 1'b1 && n < 40000) begin
                @(posedge clk_sys);
                n++;
                if (n == 2)
                    check(32'(initDoneOe), 32'(ctrl[6]), "init done held low");
                if (userClockIn && !pu)
                    ue++;
                pu = userClockIn;
            end
            if (ctrl[5])
                check(32'(ue >= `SCL_USER_EDGES && ue <= `SCL_USER_EDGES + 30), 32'h1, "user clock init");
            else
                check(32'(n >= `SCL_INIT_MIN_CYC && n <= 4370), 32'h1, "oscillator init");
            check(32'({configStatusNOe, configDoneLineOe, initDoneOe, reconfigRequestN}), 32'h1, "user lines");
            check(32'({configStatusNOut, configDoneLineOut, initDoneOut, serialCmdOe}), 32'h0, "pin levels");
            apb(1'b0, `SCL_OFS_STAT, 32'h0, q, e);
            check(q, 32'h0000_001c, "user status word");
        end else begin
            check(32'(configDoneLineOe), 32'h1, "done on short stream");
        end
        // Reference stream: passive bit order, or flash nibbles MSB first
        for (int k = 0; k < (ctrl[1] ? len / 4 : sent); k++)
            for (int j = 0; j < (ctrl[1] ? 4 : 1); j++)
                bits.push_back(image[127 - (ctrl[0] ? 4 * k : k) - (ctrl[1] ? j : (ctrl[0] ? 2 : 0))]);
        foreach (bits[i]) expData = {expData[30:0], bits[i]};
        apb(1'b0, `SCL_OFS_COUNT, 32'h0, q, e);
        check(q, 32'(sent), "bit count");
        apb(1'b0, `SCL_OFS_DATA, 32'h0, q, e);
        check(q, expData, "captured data");
        if (ctrl[0])
            check(cmdSeen, `SCL_CMD_WORD, "flash command");
        $display("test done: ctrl %h len %0d sent %0d", ctrl, len, sent);
    endtask : run

    task automatic results();
        $display("comparisons %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] q;
        logic e;
        int len3;
        void'($urandom(87566));
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(32'(configStatusNOe & configDoneLineOe), 32'h1, "power-up lines");
        apb(1'b0, `SCL_OFS_CTRL, 32'h0, q, e);
        check(q, {24'h0, `SCL_CTRL_RST}, "ctrl reset value");
        apb(1'b0, `SCL_OFS_LEN, 32'h0, q, e);
        check(q, `SCL_LEN_RST, "length reset value");
        apb(1'b0, 8'h14, 32'h0, q, e);
        check({q[30:0], e}, 32'h1, "unmapped access");
        $display("test done: reset values");
        run(8'hc0, 40, 40);
        run(8'h80, 48, 47);
        len3 = 32 + 4 * int'($urandom % 9);
        run({1'b1, 1'($urandom), 6'h03}, len3, len3);
        run({1'b1, 1'($urandom), 6'h07}, 32, 32);
        run({1'b1, 1'($urandom), 6'h09}, 32, 32);
        run({1'b1, 1'($urandom), 6'h1d}, 32, 32);
        run({1'b1, 1'($urandom), 6'h0f}, 32, 32);
        run({1'b1, 1'($urandom), 6'h20}, 32, 32);
        results();
    end

    // Watchdog sized above the expected run of about 75k cycles
    initial begin
        #9_500_000;
        errCount++;
        results();
    end
endmodule : testbench
